// ==== src/emf_pkg.sv ====
// constants, field layout and state types of the mac mii port and filter
// assumes a 100 MHz system clock and a wishbone register master
// Summary of operation
// - management reaches 32 registers on 32 phys
// - management data valid at clock rising edge
// - address register write starts one transaction
// - preamble, start, opcode, addresses, turnaround, data, idle
// - management clock output, one shared data pin
// - transmit nibbles with enable from frame start
// - receive nibbles while data valid is high
// - receive error counts only while valid high
// - carrier sense for idle, collision half duplex
// - seven preamble bytes and delimiter precede frame
// - six byte destination then source, destination checked
// - field above 05DCh is type, else length
// - tag id 8100h marks vlan frame
// - status gives pass, broadcast and multicast flags
// - first bit zero unicast, one multicast
// - broadcast accepted in pass all mode or when drop bit clear
// - perfect filter passes exact station address
// - inverse passes others, unicast only
// - hash filter uses programmed hash table
// - five control bits select filter mode
// - filter mode bits reset to 01000b
// - crc top six bits index hash table
package emf_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_MAC_CTRL  = 8'h00;
    localparam logic [7:0] OFF_STA_HIGH  = 8'h04;
    localparam logic [7:0] OFF_STA_LOW   = 8'h08;
    localparam logic [7:0] OFF_HASH_HIGH = 8'h0C;
    localparam logic [7:0] OFF_HASH_LOW  = 8'h10;
    localparam logic [7:0] OFF_MGMT_CMD  = 8'h14;
    localparam logic [7:0] OFF_MGMT_DATA = 8'h18;
    localparam logic [7:0] OFF_LINK_STAT = 8'h1C;
    // mac control fields
    localparam int CTRL_FDX_BIT  = 20;
    localparam int CTRL_FM_LO    = 15;
    localparam int CTRL_DROPB    = 11;
    localparam logic [31:0] CTRL_RST = 32'h0004_0000;
    // filter mode bit positions within the five bit field
    localparam int FM_PM = 4;
    localparam int FM_PR = 3;
    localparam int FM_IF = 2;
    localparam int FM_HO = 1;
    localparam int FM_HP = 0;
    // management address/command fields
    localparam int MA_BUSY_BIT = 0;
    localparam int MA_WR_BIT   = 1;
    localparam int MA_REG_LO   = 6;
    localparam int MA_PHY_LO   = 11;
    // management frame layout
    localparam logic [31:0] MD_PRE    = 32'hFFFF_FFFF;
    localparam logic [1:0]  MD_ST     = 2'h1;
    localparam logic [1:0]  MD_OP_RD  = 2'h2;
    localparam logic [1:0]  MD_OP_WR  = 2'h1;
    localparam logic [1:0]  MD_TA_WR  = 2'h2;
    localparam logic [6:0]  MD_TA_BIT = 7'h2E;
    localparam logic [6:0]  MD_DAT_BIT = 7'h30;
    localparam logic [6:0]  MD_IDLE_BIT = 7'h40;
    localparam logic [6:0]  MD_END_BIT  = 7'h41;
    localparam int SYS_HZ = 100_000_000;
    localparam int MDC_HZ = 2_500_000;
    localparam int MDC_HALF = SYS_HZ / (2 * MDC_HZ);
    // ethernet framing
    localparam logic [3:0]  PRE_NIB  = 4'h5;
    localparam logic [3:0]  SFD_NIB  = 4'hD;
    localparam logic [3:0]  PRE_NIBS = 4'hF;
    localparam logic [4:0]  DA_NIBS  = 5'h0C;
    localparam logic [4:0]  LT_NIB   = 5'h18;
    localparam logic [4:0]  HDR_NIBS = 5'h1C;
    localparam logic [15:0] LEN_MAX  = 16'h05DC;
    localparam logic [15:0] VLAN_TPID = 16'h8100;
    localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA} emf_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_HDR, RX_BODY} emf_rx_t;
endpackage : emf_pkg

// ==== src/emf_mac_mii.sv ====
// mac side of the mii: management master, nibble paths, address filter
// assumes mii pins and phy clocks asynchronous to clk_i; wishbone classic
`timescale 1ns/1ps
module emf_mac_mii (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    output logic             mdc_o,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe_o,
    input  wire logic        transmit_clock_i,
    output logic      [3:0]  txd_o,
    output logic             tx_en_o,
    input  wire logic        receive_clock_i,
    input  wire logic [3:0]  rxd_i,
    input  wire logic        receive_data_valid_i,
    input  wire logic        receive_error_i,
    input  wire logic        carrier_sense_i,
    input  wire logic        col_i,
    input  wire logic        tx_valid_i,
    input  wire logic [3:0]  tx_nib_i,
    output logic             tx_ready_o,
    output logic      [3:0]  rx_nib_o,
    output logic             rx_nib_valid_o,
    output logic             rx_stat_valid_o,
    output logic             rx_filter_pass_o,
    output logic             rx_bcast_o,
    output logic             rx_mcast_o,
    output logic             rx_vlan_o,
    output logic             rx_is_type_o,
    output logic             rx_err_o,
    output logic      [15:0] rx_len_type_o
);
    import emf_pkg::*;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic [31:0] ctrl;
        logic [31:0] sah;
        logic [31:0] sal;
        logic [31:0] hth;
        logic [31:0] htl;
        logic [4:0]  target_phy_addr;
        logic [4:0]  target_reg_index;
        logic        md_wr;
        logic [15:0] mgmt_data_word;
        logic        md_busy;
        logic [7:0]  md_div;
        logic        mdc;
        logic [6:0]  md_bit;
        logic [63:0] md_sh;
        logic        md_out;
        logic        md_oe;
        logic [2:0]  rc;
        logic [2:0]  tc;
        logic [1:0]  dv;
        logic [1:0]  er;
        logic [1:0]  cs;
        logic [1:0]  col;
        logic [1:0]  mdi;
        logic [3:0]  rd0;
        logic [3:0]  rd1;
        emf_rx_t     rxs;
        logic [4:0]  rx_cnt;
        logic [47:0] da;
        logic [15:0] lt;
        logic [31:0] crc;
        logic        err;
        logic [3:0]  rx_nib;
        logic        rx_nv;
        logic        stat_v;
        logic        pass;
        logic        bc;
        logic        mc;
        emf_tx_t     txs;
        logic [3:0]  tx_cnt;
        logic [3:0]  txd;
        logic        txen;
    } emf_st_t;

    emf_st_t q;
    emf_st_t d;
    logic    tx_edge;
    logic    rx_fall;
    logic    wb_req;
    logic    wb_wr;
    logic    md_tick;
    logic    tx_go;

    // merge a write through the byte lanes
    function automatic logic [31:0] wmask(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : wmask

    // crc-32 over one nibble, least significant bit first
    function automatic logic [31:0] crc_nib(input logic [31:0] c,
                                            input logic [3:0]  nib);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 4; i++) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ nib[i]) ? CRC_POLY : 32'h0);
        end
        return r;
    endfunction : crc_nib

    // destination address verdict for the selected filter mode
    function automatic logic filt_pass(input logic [47:0] da,
                                       input logic [31:0] crc,
                                       input logic [4:0]  fm,
                                       input logic        dropb,
                                       input logic [47:0] sta,
                                       input logic [63:0] ht);
        logic hit;
        hit = ht[crc[31:26]];
        if (fm[FM_PR]) return 1'b1;
        if (&da) return ~dropb;
        if (da[0]) return fm[FM_PM] | (fm[FM_HP] & hit);
        if (fm[FM_HO] & fm[FM_HP]) return hit;
        if (fm[FM_IF]) return da != sta;
        return da == sta;
    endfunction : filt_pass

    // edge events found on the synchronised phy clocks
    assign tx_edge = q.tc[1] & ~q.tc[2];
    assign rx_fall = ~q.rc[1] & q.rc[2];
    assign wb_req  = wb_cyc_i & wb_stb_i;
    assign wb_wr   = wb_req & wb_we_i & q.ack;
    assign md_tick = q.md_busy & (q.md_div == 8'(MDC_HALF - 1));
    // defer start while carrier present in half duplex
    assign tx_go   = tx_valid_i & (q.ctrl[CTRL_FDX_BIT] | ~q.cs[1]);
    // nibble taken on each rising transmit clock edge in the data state
    assign tx_ready_o = (q.txs == TX_DATA) & tx_edge & tx_valid_i
                      & ~(q.col[1] & ~q.ctrl[CTRL_FDX_BIT]);

    // next state of the whole block
    always_comb begin
        d = q;
        d.rx_nv  = 1'b0;
        d.stat_v = 1'b0;
        // two stage synchronisers on every pin input
        d.rc  = {q.rc[1:0], receive_clock_i};
        d.tc  = {q.tc[1:0], transmit_clock_i};
        d.dv  = {q.dv[0], receive_data_valid_i};
        d.er  = {q.er[0], receive_error_i};
        d.cs  = {q.cs[0], carrier_sense_i};
        d.col = {q.col[0], col_i};
        d.mdi = {q.mdi[0], mdio_i};
        d.rd0 = rxd_i;
        d.rd1 = q.rd0;
        // wishbone: ack one cycle, register reads
        d.ack = wb_req & ~q.ack;
        if (wb_req & ~q.ack) begin
            unique case (wb_adr_i)
                OFF_MAC_CTRL:  d.rdat = q.ctrl;
                OFF_STA_HIGH:  d.rdat = q.sah;
                OFF_STA_LOW:   d.rdat = q.sal;
                OFF_HASH_HIGH: d.rdat = q.hth;
                OFF_HASH_LOW:  d.rdat = q.htl;
                OFF_MGMT_CMD:  d.rdat = 32'({q.target_phy_addr,
                                   q.target_reg_index, 4'h0, q.md_wr,
                                   q.md_busy});
                OFF_MGMT_DATA: d.rdat = {16'h0, q.mgmt_data_word};
                OFF_LINK_STAT: d.rdat = {28'h0, q.txen,
                                   q.rxs != RX_IDLE, q.col[1], q.cs[1]};
                default:       d.rdat = 32'h0;
            endcase
        end
        // register writes take effect at the acknowledging edge
        if (wb_wr) begin
            unique case (wb_adr_i)
                OFF_MAC_CTRL:  d.ctrl = wmask(q.ctrl, wb_dat_i, wb_sel_i);
                OFF_STA_HIGH:  d.sah  = wmask(q.sah, wb_dat_i, wb_sel_i);
                OFF_STA_LOW:   d.sal  = wmask(q.sal, wb_dat_i, wb_sel_i);
                OFF_HASH_HIGH: d.hth  = wmask(q.hth, wb_dat_i, wb_sel_i);
                OFF_HASH_LOW:  d.htl  = wmask(q.htl, wb_dat_i, wb_sel_i);
                OFF_MGMT_DATA: d.mgmt_data_word = wb_dat_i[15:0];
                OFF_MGMT_CMD: if (!q.md_busy) begin
                    d.target_phy_addr  = wb_dat_i[MA_PHY_LO +: 5];
                    d.target_reg_index = wb_dat_i[MA_REG_LO +: 5];
                    d.md_wr   = wb_dat_i[MA_WR_BIT];
                    d.md_busy = 1'b1;
                    d.md_div  = 8'h0;
                    d.md_bit  = 7'h0;
                    d.mdc     = 1'b0;
                    // frame: preamble, start, op, addresses, data
                    // any phy address and register index
                    d.md_sh = {MD_PRE, MD_ST,
                        wb_dat_i[MA_WR_BIT] ? MD_OP_WR : MD_OP_RD,
                        wb_dat_i[MA_PHY_LO +: 5],
                        wb_dat_i[MA_REG_LO +: 5],
                        wb_dat_i[MA_WR_BIT] ? MD_TA_WR : 2'h3,
                        wb_dat_i[MA_WR_BIT] ? q.mgmt_data_word : 16'hFFFF};
                    d.md_out = 1'b1;
                    d.md_oe  = 1'b1;
                end
                default: ;
            endcase
        end
        // divided management clock, low when idle
        if (md_tick) begin
            d.md_div = 8'h0;
            d.mdc    = ~q.mdc;
            // read bits sampled at management clock rise
            // phy owns the line after turnaround
            if (!q.mdc && !q.md_wr && q.md_bit >= MD_DAT_BIT &&
                q.md_bit < MD_IDLE_BIT) begin
                d.mgmt_data_word = {q.mgmt_data_word[14:0], q.mdi[1]};
            end
            // new bit placed at the falling edge
            if (q.mdc) begin
                d.md_bit = q.md_bit + 7'h1;
                d.md_sh  = {q.md_sh[62:0], 1'b0};
                d.md_out = q.md_sh[62];
                // one shared pin, released while phy answers
                d.md_oe  = (q.md_bit + 7'h1 < MD_IDLE_BIT) &
                           (q.md_wr | (q.md_bit + 7'h1 < MD_TA_BIT));
                if (q.md_bit + 7'h1 == MD_END_BIT) begin
                    d.md_busy = 1'b0;
                    d.md_out  = 1'b0;
                end
            end
        end else if (q.md_busy) begin
            d.md_div = q.md_div + 8'h1;
        end
        // error seen only while data valid
        if (q.dv[1] && q.er[1] && q.rxs != RX_IDLE) begin
            d.err = 1'b1;
        end
        // receive framing
        unique case (q.rxs)
            RX_IDLE: if (q.dv[1]) begin
                d.rxs = RX_HUNT;
                d.err = 1'b0;
            end
            RX_HUNT: begin
                // skip preamble up to the delimiter
                if (rx_fall && q.rd1 == SFD_NIB) begin
                    d.rxs    = RX_HDR;
                    d.rx_cnt = 5'h0;
                    d.crc    = CRC_INIT;
                    d.lt     = 16'h0;
                end
            end
            RX_HDR, RX_BODY: begin
                if (rx_fall) begin
                    d.rx_nib = q.rd1;
                    d.rx_nv  = 1'b1;
                    if (q.rx_cnt < DA_NIBS) begin
                        d.da  = {q.rd1, q.da[47:4]};
                        d.crc = crc_nib(q.crc, q.rd1);
                    end else if (q.rx_cnt >= LT_NIB &&
                                 q.rx_cnt < HDR_NIBS) begin
                        d.lt[{~q.rx_cnt[1], q.rx_cnt[0]} * 4 +: 4] = q.rd1;
                    end
                    if (q.rx_cnt < HDR_NIBS) begin
                        d.rx_cnt = q.rx_cnt + 5'h1;
                    end else begin
                        d.rxs = RX_BODY;
                    end
                end
            end
            default: d.rxs = RX_IDLE;
        endcase
        // frame verdict and class reported at frame end
        if (q.rxs != RX_IDLE && !q.dv[1]) begin
            d.rxs    = RX_IDLE;
            d.stat_v = q.rxs != RX_HUNT;
            // first received bit and all ones
            d.mc   = q.da[0];
            d.bc   = &q.da;
            d.pass = filt_pass(q.da, q.crc, q.ctrl[CTRL_FM_LO +: 5],
                               q.ctrl[CTRL_DROPB], {q.sah[15:0], q.sal},
                               {q.hth, q.htl});
        end
        // transmit: preamble, delimiter, then user nibbles
        if (tx_edge) begin
            unique case (q.txs)
                TX_IDLE: if (tx_go) begin
                    d.txs    = TX_PRE;
                    d.txen   = 1'b1;
                    d.txd    = PRE_NIB;
                    d.tx_cnt = 4'h1;
                end
                TX_PRE: begin
                    d.tx_cnt = q.tx_cnt + 4'h1;
                    d.txd    = (q.tx_cnt < PRE_NIBS) ? PRE_NIB : SFD_NIB;
                    if (q.tx_cnt == PRE_NIBS) d.txs = TX_DATA;
                end
                TX_DATA: begin
                    // data nibbles while source supplies them
                    d.txd = tx_nib_i;
                    if (!tx_valid_i) begin
                        d.txs  = TX_IDLE;
                        d.txen = 1'b0;
                        d.txd  = 4'h0;
                    end
                end
                default: d.txs = TX_IDLE;
            endcase
            if (q.col[1] && !q.ctrl[CTRL_FDX_BIT] && q.txs != TX_IDLE) begin
                d.txs  = TX_IDLE;
                d.txen = 1'b0;
                d.txd  = 4'h0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q      <= '0;
            // filter mode resets to pass all
            q.ctrl <= CTRL_RST;
            q.rxs  <= RX_IDLE;
            q.txs  <= TX_IDLE;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops, type and vlan flags decoded from the length/type flop
    assign wb_ack_o  = q.ack;
    assign wb_dat_o  = q.rdat;
    assign mdc_o     = q.mdc;
    assign mdio_o    = q.md_out;
    assign mdio_oe_o = q.md_oe;
    assign txd_o     = q.txd;
    assign tx_en_o   = q.txen;
    assign rx_nib_o  = q.rx_nib;
    assign rx_nib_valid_o   = q.rx_nv;
    assign rx_stat_valid_o  = q.stat_v;
    assign rx_filter_pass_o = q.pass;
    assign rx_bcast_o = q.bc;
    assign rx_mcast_o = q.mc;
    assign rx_err_o   = q.err;
    assign rx_len_type_o = q.lt;
    assign rx_is_type_o = q.lt > LEN_MAX;
    assign rx_vlan_o = q.lt == VLAN_TPID;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_mdc_idle_low: assert property (!q.md_busy |-> !mdc_o)
        else $error("management clock not low while idle");
    a_mdio_idle_rel: assert property (!q.md_busy |-> !mdio_oe_o)
        else $error("data pin driven while idle");
    a_cmd_starts: assert property (wb_wr && wb_adr_i == OFF_MGMT_CMD
        && !q.md_busy |=> q.md_busy && mdio_oe_o && mdio_o)
        else $error("command write did not start a transaction");
    a_read_release: assert property (q.md_busy && !q.md_wr
        && q.md_bit >= MD_TA_BIT |-> !mdio_oe_o)
        else $error("pin driven while phy answers");
    a_tx_pre_first: assert property ($rose(tx_en_o)
        |-> txd_o == PRE_NIB && $past(q.ctrl[CTRL_FDX_BIT] || !q.cs[1]))
        else $error("frame start without preamble or during carrier");
    a_bcast_is_mc: assert property (rx_stat_valid_o && rx_bcast_o
        |-> rx_mcast_o)
        else $error("broadcast not flagged multicast");
    a_bcast_pass: assert property (rx_stat_valid_o && rx_bcast_o
        && !q.ctrl[CTRL_DROPB] |-> rx_filter_pass_o)
        else $error("broadcast rejected");
    a_promisc_pass: assert property (rx_stat_valid_o
        && q.ctrl[CTRL_FM_LO + FM_PR] |-> rx_filter_pass_o)
        else $error("pass all mode rejected a frame");
    a_vlan_type: assert property (rx_vlan_o |-> rx_is_type_o)
        else $error("vlan tag not read as type");
    a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule : emf_mac_mii

// ==== dv/emf_phy_model.sv ====
// phy stand-in: link clocks, management slave, frame source and sink
// assumes mdc idles low and the bench resolves the pulled-up mdio wire
`timescale 1ns/1ps
module emf_phy_model #(
    parameter logic [15:0] RDAT = 16'hA5C3
) (
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe_o,
    output logic            transmit_clock_in_o,
    output logic            receive_clock_in_o,
    input  wire logic [3:0] txd_i,
    input  wire logic       tx_en_i,
    output logic      [3:0] rxd_o,
    output logic            dv_o,
    output logic            er_o
);
    logic [63:0] sh = '0;
    logic [6:0]  cnt = '0;
    logic        rd = 1'b0;
    logic [3:0]  txq[$];
    // error line high while idle, where it must be ignored
    initial {mdio_o, mdio_oe_o, transmit_clock_in_o, receive_clock_in_o, rxd_o, dv_o, er_o} = 10'h001;
    always #40 transmit_clock_in_o = ~transmit_clock_in_o;
    initial #13 forever #40 receive_clock_in_o = ~receive_clock_in_o;
    always @(posedge mdc_i) begin
        sh  <= {sh[62:0], mdio_i};
        rd  <= (cnt == 7'd35) ? ({sh[0], mdio_i} == 2'b10) : rd;
        cnt <= (cnt == 7'd64) ? 7'd0 : cnt + 7'd1;
    end
    always @(negedge mdc_i) begin
        mdio_oe_o <= rd && cnt > 7'd46 && cnt < 7'd64;
        mdio_o    <= cnt > 7'd47 && cnt < 7'd64 && RDAT[7'd63 - cnt];
    end
    task automatic send(input logic [7:0] b[16], input int ep);
        logic [3:0] n;
        for (int i = 0; i < 48; i++) begin
            n = i < 15 ? 4'h5 : i == 15 ? 4'hD : b[(i - 16) / 2][4 * (i % 2) +: 4];
            @(posedge receive_clock_in_o);
            {dv_o, er_o} <= {1'b1, i == ep};
            rxd_o <= n;
        end
        @(posedge receive_clock_in_o);
        {dv_o, er_o} <= 2'b01;
        rxd_o <= ~n;
    endtask : send
    always @(posedge transmit_clock_in_o) if (tx_en_i) txq.push_back(txd_i);
endmodule : emf_phy_model

// ==== dv/emf_mac_mii_tb.sv ====
// bench: registers, management, receive filter and transmit
// assumes emf_phy_model on the far side; mdio has a pull-up
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end
module emf_mac_mii_tb;
    import emf_pkg::*;
    localparam logic [15:0] PW = 16'hA5C3;
    localparam logic [39:0] MODES = {5'h00, 5'h13, 5'h03, 5'h10, 5'h01, 5'h04, 5'h00, 5'h08};
    logic        clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, txv = 0, ack;
    logic [7:0]  adr = '0;
    logic [31:0] wd = '0, rd, q;
    logic [3:0]  txn = '0, txd, rxd, rxn, rlast;
    logic        col = 1'b0;
    logic        mdc, mdo, mdoe, pdo, pdoe, txc, rxc, txen, dv, er;
    logic        txr, rxnv, sv, fp, bc, mc, vl, ty, re;
    logic [15:0] lt;
    logic [47:0] sta;
    logic [63:0] ht;
    wire         mdio_w = mdoe ? mdo : (pdoe ? pdo : 1'b1);
    int          err_total = 0, cmp_count = 0, seed = 89699, ncyc = 0, nnib = 0;
    always #5 clk_i = ~clk_i;
    emf_mac_mii i_emf_mac_mii (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wd), .wb_dat_o(rd), .wb_sel_i(4'hF), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .mdc_o(mdc),
        .mdio_i(mdio_w), .mdio_o(mdo), .mdio_oe_o(mdoe), .transmit_clock_i(txc),
        .txd_o(txd), .tx_en_o(txen), .receive_clock_i(rxc), .rxd_i(rxd),
        .receive_data_valid_i(dv), .receive_error_i(er), .carrier_sense_i(dv),
        .col_i(col), .tx_valid_i(txv), .tx_nib_i(txn), .tx_ready_o(txr),
        .rx_nib_o(rxn), .rx_nib_valid_o(rxnv), .rx_stat_valid_o(sv),
        .rx_filter_pass_o(fp), .rx_bcast_o(bc), .rx_mcast_o(mc),
        .rx_vlan_o(vl), .rx_is_type_o(ty), .rx_err_o(re), .rx_len_type_o(lt));
    emf_phy_model #(.RDAT(PW)) i_emf_phy_model (.mdc_i(mdc), .mdio_i(mdio_w),
        .mdio_o(pdo), .mdio_oe_o(pdoe), .transmit_clock_in_o(txc), .receive_clock_in_o(rxc),
        .txd_i(txd), .tx_en_i(txen), .rxd_o(rxd), .dv_o(dv), .er_o(er));
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // nibble count and hang limit
    always @(posedge clk_i) begin
        nnib <= nnib + int'(rxnv === 1'b1);
        if (rxnv === 1'b1) rlast <= rxn;
        ncyc <= ncyc + 1;
        if (ncyc == 40000) begin
            err_total++;
            results();
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rd;
        `CHK(ack, 1'b1)
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    function automatic logic fexp(input logic [4:0] m, input logic dr,
                                  input logic [47:0] da);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 48; i++)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? CRC_POLY : 32'h0);
        if (m[3] || &da) return m[3] || !dr;
        if (da[0]) return m[4] || (m[0] && ht[c[31:26]]);
        return (m[1] && m[0]) ? ht[c[31:26]] : (m[2] ? da != sta : da == sta);
    endfunction : fexp
    initial begin
        logic [47:0] da;
        logic [63:0] f;
        logic [15:0] md, lx;
        logic [4:0]  m, pa, ra;
        logic [7:0]  fr[16];
        int e, n, n0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, OFF_MAC_CTRL, 0);
        `CHK(q, CTRL_RST)
        wb(1, 8'h24, $random(seed));
        wb(0, 8'h24, 0);
        `CHK(q, 32'h0)
        // a write then a read on the serial bus
        for (int k = 1; k >= 0; k--) begin
            {pa, ra, md} = 26'($random(seed));
            wb(1, OFF_MGMT_DATA, {16'h0, md});
            wb(1, OFF_MGMT_CMD, {16'h0, pa, ra, 4'h0, k[0], 1'b0});
            n = 0;
            do begin
                wb(0, OFF_MGMT_CMD, 0);
                if (n == 0) `CHK(q[MA_BUSY_BIT], 1'b1)
                n++;
            end while (q[MA_BUSY_BIT] !== 1'b0 && n < 2000);
            f = {MD_PRE, MD_ST, k[0] ? MD_OP_WR : MD_OP_RD, pa, ra, 2'b10,
                 k[0] ? md : PW};
            `CHK(i_emf_phy_model.sh, {f[62:0], 1'b1})
            wb(0, OFF_MGMT_DATA, 0);
            `CHK(q[15:0], k[0] ? md : PW)
        end
        $display("test management done");
        sta = 48'({$random(seed), $random(seed)});
        sta[0] = 1'b0;
        ht = {$random(seed), $random(seed)};
        wb(1, OFF_STA_LOW, sta[31:0]);
        wb(1, OFF_STA_HIGH, {16'h0, sta[47:32]});
        wb(1, OFF_HASH_LOW, ht[31:0]);
        wb(1, OFF_HASH_HIGH, ht[63:32]);
        // every frame kind under every filter mode
        for (int i = 0; i < 8; i++) begin
            m = MODES[5 * i +: 5];
            wb(1, OFF_MAC_CTRL, {12'h0, m, 3'h0, i == 7, 11'h0});
            for (int t = 0; t < 4; t++) begin
                da = 48'({$random(seed), $random(seed)});
                da[0] = t[1];
                if (t == 0) da = sta;
                if (t == 3) da = '1;
                lx = t == 2 ? VLAN_TPID : t == 3 ? 16'($random(seed)) : LEN_MAX + t[0];
                for (int j = 0; j < 16; j++) fr[j] = $random(seed);
                for (int j = 0; j < 6; j++) fr[j] = da[8 * j +: 8];
                {fr[12], fr[13]} = lx;
                n0 = nnib;
                i_emf_phy_model.send(fr, t == 1 ? 20 : -1);
                for (n = 0; n < 50 && sv !== 1'b1; n++) @(posedge clk_i);
                `CHK(fp, fexp(m, i == 7, da))
                `CHK({bc, mc}, {&da, da[0]})
                `CHK({re, lt, vl}, {t == 1, lx, lx == VLAN_TPID})
                if (t != 2) `CHK(ty, lx > LEN_MAX)
                `CHK(nnib - n0, 32)
                `CHK(rlast, fr[15][7:4])
            end
        end
        $display("test receive filter done");
        // short frame out, nibbles 3, 6, 9, C
        i_emf_phy_model.txq.delete();
        {txv, txn} <= 5'h13;
        e = 0;
        while (e < 4) begin
            @(posedge clk_i);
            if (txr === 1'b1) begin
                e++;
                txn <= txn + 4'h3;
                txv <= e < 4;
            end
        end
        for (n = 0; n < 200 && txen !== 1'b0; n++) @(posedge clk_i);
        repeat (20) @(posedge clk_i);
        `CHK(i_emf_phy_model.txq.size(), 20)
        for (int j = 0; j < 20; j++)
            `CHK(i_emf_phy_model.txq[j], j < 15 ? PRE_NIB : j == 15 ? SFD_NIB : 4'(3 * (j - 15)))
        // collision in half duplex cuts the frame short
        txv <= 1'b1;
        for (n = 0; n < 200 && txen !== 1'b1; n++) @(posedge clk_i);
        {col, txv} <= 2'b10;
        repeat (20) @(posedge clk_i);
        `CHK(txen, 1'b0)
        wb(0, OFF_LINK_STAT, 0);
        `CHK(q, 32'h2)
        col <= 1'b0;
        $display("test transmit done");
        results();
    end
endmodule : emf_mac_mii_tb
